// ==== spr_pkg.sv ====
package spr_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PEAK_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [7:0] IDX_OUT_LO = 8'h1a;
    localparam logic [7:0] IDX_OUT_HI = 8'h1b;
    localparam logic [7:0] IDX_ERR_LO = 8'h38;
    localparam logic [7:0] IDX_ERR_HI = 8'h39;
    localparam int WORD_BYTES = 4;
    localparam logic [ADDR_W-1:0] ADDR_OUT_LO = ADDR_W'(IDX_OUT_LO * WORD_BYTES);
    localparam logic [ADDR_W-1:0] ADDR_OUT_HI = ADDR_W'(IDX_OUT_HI * WORD_BYTES);
    localparam logic [ADDR_W-1:0] ADDR_ERR_LO = ADDR_W'(IDX_ERR_LO * WORD_BYTES);
    localparam logic [ADDR_W-1:0] ADDR_ERR_HI = ADDR_W'(IDX_ERR_HI * WORD_BYTES);

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int LO_MSB = 7;
    localparam int LO_LSB = 0;
    localparam int HI_MSB = 15;
    localparam int HI_LSB = 8;
    localparam logic [PEAK_W-1:0] PEAK_RESET = 16'h0000;
    localparam logic [PEAK_W-1:0] PEAK_POS_MAX = 16'h7fff;
    localparam logic [PEAK_W-1:0] PEAK_NEG_MIN = 16'h8000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    localparam logic [DATA_W-BYTE_W-1:0] PAD_ZERO = 24'h00_0000;
    localparam int WINDOW_SAMPLES = 256;

    // ------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : spr_pkg

// ==== spr_peak_track.sv ====
`timescale 1ns/100ps
`default_nettype none

module spr_peak_track #(
    parameter int WIDTH = spr_pkg::PEAK_W,
    parameter int WINDOW = spr_pkg::WINDOW_SAMPLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // monitored signal
    input wire logic [WIDTH-1:0] sample,
    input wire logic sample_valid,
    // published peak
    output logic [WIDTH-1:0] peak_r,
    output logic pub_r
);

    localparam int CNT_W = (WINDOW > 1) ? $clog2(WINDOW) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WINDOW - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    logic [WIDTH-1:0] cur_r;
    logic [CNT_W-1:0] cnt_r;
    logic [WIDTH-1:0] mag;
    logic [WIDTH-1:0] best;
    logic last;

    // ------------------------------------------------------------
    // magnitude, saturating the most negative value
    // ------------------------------------------------------------
    assign mag = !sample[WIDTH-1] ? sample :
                 (sample == spr_pkg::PEAK_NEG_MIN) ? spr_pkg::PEAK_POS_MAX :
                 WIDTH'(-sample);
    assign best = (mag > cur_r) ? mag : cur_r;
    assign last = (cnt_r == CNT_LAST);

    // ------------------------------------------------------------
    // window peak hold, published as one word
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_r <= spr_pkg::PEAK_RESET;
            cnt_r <= '0;
            peak_r <= spr_pkg::PEAK_RESET;
            pub_r <= 1'b0;
        end else begin
            pub_r <= sample_valid && last;
            if (sample_valid && last) begin
                peak_r <= best;
                cur_r <= spr_pkg::PEAK_RESET;
                cnt_r <= '0;
            end else if (sample_valid) begin
                cur_r <= best;
                cnt_r <= cnt_r + CNT_ONE;
            end
        end
    end

endmodule : spr_peak_track

`default_nettype wire

// ==== spr_top.sv ====
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module spr_top #(
    parameter int WINDOW = spr_pkg::WINDOW_SAMPLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // monitored send-path samples
    input wire logic [spr_pkg::PEAK_W-1:0] error_tap_point,
    input wire logic error_tap_valid,
    input wire logic [spr_pkg::PEAK_W-1:0] output_tap_point,
    input wire logic output_tap_valid,
    // axi4-lite write address
    input wire logic [spr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [spr_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [spr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [spr_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic [spr_pkg::PEAK_W-1:0] residual_peak_bits;
    logic [spr_pkg::PEAK_W-1:0] outgoing_peak_bits;
    logic err_pub;
    logic out_pub;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [spr_pkg::ADDR_W-1:0] awaddr_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [spr_pkg::DATA_W-1:0] rdata_r;

    // ------------------------------------------------------------
    // peak trackers
    // ------------------------------------------------------------
    spr_peak_track #(
        .WIDTH(spr_pkg::PEAK_W),
        .WINDOW(WINDOW)
    ) u_err_peak (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample(error_tap_point),
        .sample_valid(error_tap_valid),
        .peak_r(residual_peak_bits),
        .pub_r(err_pub)
    );

    spr_peak_track #(
        .WIDTH(spr_pkg::PEAK_W),
        .WINDOW(WINDOW)
    ) u_out_peak (
        .aclk(aclk),
        .aresetn(aresetn),
        .sample(output_tap_point),
        .sample_valid(output_tap_valid),
        .peak_r(outgoing_peak_bits),
        .pub_r(out_pub)
    );

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    wire rd_hit_out_lo = (s_axi_araddr == spr_pkg::ADDR_OUT_LO);
    wire rd_hit_out_hi = (s_axi_araddr == spr_pkg::ADDR_OUT_HI);
    wire rd_hit_err_lo = (s_axi_araddr == spr_pkg::ADDR_ERR_LO);
    wire rd_hit_err_hi = (s_axi_araddr == spr_pkg::ADDR_ERR_HI);
    wire rd_mapped = rd_hit_out_lo || rd_hit_out_hi || rd_hit_err_lo || rd_hit_err_hi;
    wire [spr_pkg::BYTE_W-1:0] rd_byte;

    assign rd_byte = rd_hit_out_lo ? outgoing_peak_bits[spr_pkg::LO_MSB:spr_pkg::LO_LSB] :
                     rd_hit_out_hi ? outgoing_peak_bits[spr_pkg::HI_MSB:spr_pkg::HI_LSB] :
                     rd_hit_err_lo ? residual_peak_bits[spr_pkg::LO_MSB:spr_pkg::LO_LSB] :
                     rd_hit_err_hi ? residual_peak_bits[spr_pkg::HI_MSB:spr_pkg::HI_LSB] :
                     '0;

    wire rd_take = s_axi_arvalid && arready_r;
    wire [spr_pkg::DATA_W-1:0] rdata_nxt = {spr_pkg::PAD_ZERO, rd_byte};
    wire [1:0] rresp_nxt = rd_mapped ? spr_pkg::RESP_OKAY : spr_pkg::RESP_SLVERR;

    // ------------------------------------------------------------
    // read channel, no side effect on any state
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= spr_pkg::DATA_ZERO;
            rresp_r <= spr_pkg::RESP_OKAY;
        end else if (rd_take) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // write channel, data discarded
    // ------------------------------------------------------------
    wire aw_take = s_axi_awvalid && awready_r;
    wire w_take = s_axi_wvalid && wready_r;
    wire [spr_pkg::ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : awaddr_r;
    wire wr_mapped = (wr_addr == spr_pkg::ADDR_OUT_LO) || (wr_addr == spr_pkg::ADDR_OUT_HI) ||
                     (wr_addr == spr_pkg::ADDR_ERR_LO) || (wr_addr == spr_pkg::ADDR_ERR_HI);
    wire aw_done = !awready_r || aw_take;
    wire w_done = !wready_r || w_take;
    wire wr_finish = aw_done && w_done && !bvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= spr_pkg::RESP_OKAY;
            awaddr_r <= '0;
        end else begin
            if (aw_take) begin
                awready_r <= 1'b0;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                wready_r <= 1'b0;
            end
            if (wr_finish) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_mapped ? spr_pkg::RESP_OKAY : spr_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_err_lo_read;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && s_axi_araddr == spr_pkg::ADDR_ERR_LO) |=>
            rvalid_r && rdata_r[7:0] == $past(residual_peak_bits[7:0]);
    endproperty
    a_err_lo_read: assert property (p_err_lo_read) else $error("error low byte wrong");

    property p_out_hi_read;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && s_axi_araddr == spr_pkg::ADDR_OUT_HI) |=>
            rvalid_r && rdata_r[7:0] == $past(outgoing_peak_bits[15:8]);
    endproperty
    a_out_hi_read: assert property (p_out_hi_read) else $error("output high byte wrong");

    property p_upper_zero;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_r |-> rdata_r[31:8] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

    property p_err_hi_read;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && s_axi_araddr == spr_pkg::ADDR_ERR_HI) |=>
            rresp_r == spr_pkg::RESP_OKAY && rdata_r[7:0] == $past(residual_peak_bits[15:8]);
    endproperty
    a_err_hi_read: assert property (p_err_hi_read) else $error("error high byte wrong");

    property p_err_reset;
        @(posedge aclk)
        $rose(aresetn) |-> residual_peak_bits == '0 && !rvalid_r;
    endproperty
    a_err_reset: assert property (p_err_reset) else $error("error peak not zero after reset");

    property p_out_reset;
        @(posedge aclk)
        $rose(aresetn) |-> outgoing_peak_bits == '0 && !bvalid_r;
    endproperty
    a_out_reset: assert property (p_out_reset) else $error("output peak not zero after reset");

    property p_peak_stable;
        @(posedge aclk) disable iff (!aresetn)
        !err_pub && !out_pub |-> $stable(residual_peak_bits) && $stable(outgoing_peak_bits);
    endproperty
    a_peak_stable: assert property (p_peak_stable) else $error("peak moved without publish");

    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn)
        (aw_take && w_take && !bvalid_r) |=> bvalid_r ##0 (awready_r == 1'b0) [*1];
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response late");

    property p_out_lo_read;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && s_axi_araddr == spr_pkg::ADDR_OUT_LO) |=>
            rvalid_r && rdata_r[spr_pkg::LO_MSB:spr_pkg::LO_LSB] ==
            $past(outgoing_peak_bits[spr_pkg::LO_MSB:spr_pkg::LO_LSB]);
    endproperty
    a_out_lo_read: assert property (p_out_lo_read) else $error("output low byte wrong");

    property p_read_unmapped;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && !rd_mapped) |=>
            rresp_r == spr_pkg::RESP_SLVERR && rdata_r == spr_pkg::DATA_ZERO;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) else $error("bad unmapped read");

    property p_read_okay;
        @(posedge aclk) disable iff (!aresetn)
        (rd_take && rd_mapped) |=> rvalid_r && rresp_r == spr_pkg::RESP_OKAY;
    endproperty
    a_read_okay: assert property (p_read_okay) else $error("mapped read refused");

    property p_read_busy;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_r |-> !arready_r;
    endproperty
    a_read_busy: assert property (p_read_busy) else $error("read open while busy");

    property p_read_done;
        @(posedge aclk) disable iff (!aresetn)
        (rvalid_r && s_axi_rready) |=> !rvalid_r && arready_r;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read not retired");

    property p_write_done;
        @(posedge aclk) disable iff (!aresetn)
        (bvalid_r && s_axi_bready) |=> !bvalid_r && awready_r && wready_r;
    endproperty
    a_write_done: assert property (p_write_done) else $error("write not retired");

    property p_write_unmapped;
        @(posedge aclk) disable iff (!aresetn)
        (wr_finish && !wr_mapped) |=> bvalid_r && bresp_r == spr_pkg::RESP_SLVERR;
    endproperty
    a_write_unmapped: assert property (p_write_unmapped) else $error("bad unmapped write");

    property p_peak_sign;
        @(posedge aclk) disable iff (!aresetn)
        !residual_peak_bits[spr_pkg::HI_MSB] && !outgoing_peak_bits[spr_pkg::HI_MSB];
    endproperty
    a_peak_sign: assert property (p_peak_sign) else $error("peak magnitude negative");

    property p_err_pub_src;
        @(posedge aclk) disable iff (!aresetn)
        err_pub |-> $past(error_tap_valid);
    endproperty
    a_err_pub_src: assert property (p_err_pub_src) else $error("error peak without sample");

    property p_out_pub_src;
        @(posedge aclk) disable iff (!aresetn)
        out_pub |-> $past(output_tap_valid);
    endproperty
    a_out_pub_src: assert property (p_out_pub_src) else $error("output peak without sample");

    property p_reset_idle;
        @(posedge aclk)
        $rose(aresetn) |-> arready_r && awready_r && wready_r && rdata_r == spr_pkg::DATA_ZERO;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");

endmodule : spr_top

`default_nettype wire

// ==== spr_top_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module spr_top_tb_top;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    localparam int W = 4;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] error_tap_point = 16'h0000;
    logic error_tap_valid = 1'b0;
    logic [15:0] output_tap_point = 16'h0000;
    logic output_tap_valid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b1;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b1;
    int num_errors = 0;
    int checks_done = 0;
    int mx[2];
    int cnt[2];
    logic [15:0] pk[2];
    logic [31:0] d;
    logic [1:0] r;

    always #20 aclk = ~aclk;

    spr_top #(.WINDOW(W)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .error_tap_point(error_tap_point), .error_tap_valid(error_tap_valid),
        .output_tap_point(output_tap_point), .output_tap_valid(output_tap_valid),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic close_out;
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        dat = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [1:0] exp_resp);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= $urandom;
        s_axi_wstrb <= 4'($urandom);
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, exp_resp});
    endtask : wr

    // ------------------------------------------------------------
    // peak model and stimulus
    // ------------------------------------------------------------
    function automatic int mag(input logic [15:0] s);
        int v;
        v = $signed(s);
        if (v < 0) v = -v;
        if (v > 32767) v = 32767;
        return v;
    endfunction : mag

    task automatic model_clear;
        for (int k = 0; k < 2; k++) begin
            mx[k] = 0;
            cnt[k] = 0;
            pk[k] = 16'h0000;
        end
    endtask : model_clear

    task automatic feed(input int n);
        logic [15:0] s[2];
        logic v[2];
        for (int i = 0; i < n; i++) begin
            s[0] = (i % 5 == 3) ? 16'h8000 : 16'($urandom);
            s[1] = (i % 7 == 2) ? 16'h7fff : 16'($urandom);
            v[0] = 1'($urandom);
            v[1] = 1'($urandom);
            error_tap_point <= s[0];
            error_tap_valid <= v[0];
            output_tap_point <= s[1];
            output_tap_valid <= v[1];
            for (int k = 0; k < 2; k++) begin
                if (v[k]) begin
                    if (mag(s[k]) > mx[k]) mx[k] = mag(s[k]);
                    cnt[k]++;
                    if (cnt[k] == W) begin
                        pk[k] = 16'(mx[k]);
                        mx[k] = 0;
                        cnt[k] = 0;
                    end
                end
            end
            @(posedge aclk);
        end
        error_tap_valid <= 1'b0;
        output_tap_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : feed

    task automatic chk_peaks;
        logic [7:0] at[4];
        logic [7:0] e;
        at = '{spr_pkg::ADDR_ERR_LO, spr_pkg::ADDR_ERR_HI, spr_pkg::ADDR_OUT_LO,
            spr_pkg::ADDR_OUT_HI};
        for (int k = 0; k < 4; k++) begin
            e = (k % 2) ? pk[k/2][15:8] : pk[k/2][7:0];
            rd(at[k], d, r);
            chk(d, {24'h00_0000, e});
            chk({30'h0, r}, {30'h0, spr_pkg::RESP_OKAY});
        end
    endtask : chk_peaks

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        close_out();
    end

    initial begin
        void'($urandom(32'h456c));
        model_clear();
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_peaks();
        rd(8'he8, d, r);
        chk({30'h0, r}, {30'h0, spr_pkg::RESP_SLVERR});
        chk(d, spr_pkg::DATA_ZERO);
        wr(spr_pkg::ADDR_ERR_LO, spr_pkg::RESP_OKAY);
        wr(spr_pkg::ADDR_OUT_HI, spr_pkg::RESP_OKAY);
        wr(8'h00, spr_pkg::RESP_SLVERR);
        chk_peaks();
        repeat (6) begin
            feed(12);
            chk_peaks();
            wr(spr_pkg::ADDR_ERR_HI, spr_pkg::RESP_OKAY);
            chk_peaks();
        end
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        model_clear();
        @(posedge aclk);
        chk_peaks();
        feed(10);
        chk_peaks();
        close_out();
    end
endmodule : spr_top_tb_top

`default_nettype wire
